// ### design/rup_pkg.sv
package rup_pkg;
  localparam int CTRL_W = 39;
  localparam int CTRL_RSV_HIGH = 38;
  localparam int CTRL_EARLY_DONE = 37;
  localparam int CTRL_OSC_INT = 36;
  localparam int CTRL_WATCHDOG_ENABLE = 35;
  localparam int CTRL_RSV_LOW = 34;
  localparam int CTRL_ADDR_MSB = 33;
  localparam int CTRL_ADDR_LSB = 12;
  localparam int CTRL_WD_MSB = 11;
  localparam int CTRL_WD_LSB = 0;
  localparam int ADDR_FIELD_W = 22;
  localparam int BOOT_ADDR_W = 24;
  localparam int WD_FIELD_W = 12;
  localparam int WD_COUNT_W = 29;
  localparam logic [16:0] WD_LOW_BITS = 17'h00008;
  localparam logic [1:0] BOOT_ADDR_PAD = 2'h0;
  localparam logic [38:0] CTRL_RESET = 39'h0000000000;
  localparam logic [23:0] AS_FACTORY_ADDR = 24'h000000;
  localparam logic [23:0] AP_FACTORY_ADDR = 24'h010000;
  localparam int STATUS_W = 32;
  localparam logic [31:0] STATUS_RESET = 32'h00000000;
  localparam int ST_SRC_MSB = 30;
  localparam int ST_SRC_LSB = 26;
  localparam int ST_STATE_MSB = 25;
  localparam int ST_STATE_LSB = 24;
  localparam int SRC_W = 5;
  localparam int SRC_CFG_PIN = 4;
  localparam int SRC_CRC = 3;
  localparam int SRC_EXT_STATUS = 2;
  localparam int SRC_WATCHDOG = 1;
  localparam int SRC_FABRIC = 0;
  localparam logic [1:0] MSTATE_FACTORY = 2'h0;
  localparam logic [1:0] MSTATE_APPLICATION = 2'h1;
endpackage : rup_pkg

// ### design/rup_sync.sv
`timescale 1ns/100ps
module rup_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  // The first stage is read only by the second stage.
  always_ff @(posedge clk)
  begin
    meta <= d;
    q <= meta;
  end
endmodule : rup_sync

// ### design/rup_word_xfer.sv
`timescale 1ns/100ps
module rup_word_xfer #(
  parameter int WIDTH = 39
) (
  input wire logic src_clk,
  input wire logic src_rst_n,
  input wire logic src_load,
  input wire logic [WIDTH-1:0] src_data,
  input wire logic dst_clk,
  input wire logic dst_rst_n,
  output logic [WIDTH-1:0] dst_data
);
  logic [WIDTH-1:0] hold;
  logic src_tog;
  logic dst_tog;
  logic dst_tog_d;

  // The held word stays still until the toggle has crossed, so loads must be a few destination cycles apart.
  always_ff @(posedge src_clk)
  begin
    if (!src_rst_n)
    begin
      hold <= '0;
      src_tog <= 1'b0;
    end
    else if (src_load)
    begin
      hold <= src_data;
      src_tog <= ~src_tog;
    end
  end

  rup_sync #(.WIDTH(1)) tog_sync (
    .clk(dst_clk),
    .d(src_tog),
    .q(dst_tog)
  );

  always_ff @(posedge dst_clk)
  begin
    if (!dst_rst_n)
    begin
      dst_tog_d <= 1'b0;
      dst_data <= '0;
    end
    else
    begin
      dst_tog_d <= dst_tog;
      if (dst_tog != dst_tog_d)
        dst_data <= hold;
    end
  end
endmodule : rup_word_xfer

// ### design/rup_remote_upgrade_regs.sv
`timescale 1ns/100ps
module rup_remote_upgrade_regs (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic UPG_USER_CLOCK,
  input wire logic UPG_SERIAL_IN,
  input wire logic UPG_SHIFT_NOT_LOAD,
  input wire logic UPG_CAPTURE_NOT_UPDATE,
  input wire logic UPG_READ_STATUS,
  output logic UPG_SERIAL_OUT,
  input wire logic UPG_RECONFIG_REQUEST_N,
  input wire logic FACTORY_IMAGE,
  input wire logic ACTIVE_PARALLEL_SCHEME,
  input wire logic SET_FACTORY_ADDR,
  input wire logic [rup_pkg::BOOT_ADDR_W-1:0] SET_FACTORY_ADDR_VALUE,
  input wire logic CONFIG_RESET_N,
  input wire logic EXT_STATUS_N,
  input wire logic CRC_ERROR,
  input wire logic WATCHDOG_TIMEOUT,
  input wire logic CONFIG_DONE,
  input wire logic CONFIG_LOADING,
  input wire logic IMAGE_CHECK_FAIL,
  output logic RECONFIG_START,
  output logic FACTORY_FALLBACK,
  output logic [rup_pkg::BOOT_ADDR_W-1:0] BOOT_ADDRESS,
  output logic [rup_pkg::WD_COUNT_W-1:0] WATCHDOG_COUNT,
  output logic WATCHDOG_ENABLE,
  output logic STARTUP_OSC_SELECT,
  output logic EARLY_DONE_CHECK
);
  import rup_pkg::*;

  typedef enum logic [1:0] {RCF_IDLE, RCF_CAPTURE, RCF_ISSUE} rup_rcf_t;

  function automatic logic [SRC_W-1:0] top_source(input logic [SRC_W-1:0] pend);
    logic [SRC_W-1:0] pick;
    pick = '0;
    for (int i = 0; i < SRC_W; i++)
      if (pend[i])
        pick = '0 | (SRC_W'(1) << i);
    return pick;
  endfunction : top_source

  // Reference domain: control, status and reconfiguration sequencing.
  rup_rcf_t state;
  rup_rcf_t next_state;
  logic [CTRL_W-1:0] control;
  logic [CTRL_W-1:0] next_control;
  logic [STATUS_W-1:0] status;
  logic [STATUS_W-1:0] next_status;
  logic [CTRL_W-1:0] update_copy;
  logic [ADDR_FIELD_W-1:0] factory_base;
  logic [SRC_W-1:0] src_pend;
  logic [SRC_W-1:0] src_event;
  logic [SRC_W-1:0] src_onehot;
  logic [4:0] pin_sync;
  logic cfg_n_d;
  logic ext_n_d;
  logic req_n_d;
  logic init_pending;
  logic fallback_ev;
  logic start_q;
  logic ctrl_write;
  logic premature_done;
  logic image_bad;
  logic [CTRL_W-1:0] init_ctrl;
  logic [CTRL_W-1:0] factory_ctrl;
  logic [1:0] mstate;

  // Pins and the fabric request are not on this clock.
  rup_sync #(.WIDTH(5)) ref_pins (
    .clk(REF_CLK),
    .d({CONFIG_RESET_N, EXT_STATUS_N, UPG_RECONFIG_REQUEST_N, CONFIG_DONE, ACTIVE_PARALLEL_SCHEME}),
    .q(pin_sync)
  );

  assign src_event[SRC_CFG_PIN] = cfg_n_d & ~pin_sync[4];
  assign src_event[SRC_CRC] = CRC_ERROR;
  assign src_event[SRC_EXT_STATUS] = ext_n_d & ~pin_sync[3];
  assign src_event[SRC_WATCHDOG] = WATCHDOG_TIMEOUT;
  assign src_event[SRC_FABRIC] = req_n_d & ~pin_sync[2];
  assign src_onehot = top_source(src_pend);
  assign mstate = FACTORY_IMAGE ? MSTATE_FACTORY : MSTATE_APPLICATION;

  assign premature_done = control[CTRL_EARLY_DONE] & CONFIG_LOADING & pin_sync[1];
  assign image_bad = control[CTRL_EARLY_DONE] & IMAGE_CHECK_FAIL;

  assign factory_ctrl = {control[CTRL_RSV_HIGH:CTRL_RSV_LOW], factory_base, control[CTRL_WD_MSB:CTRL_WD_LSB]};
  assign init_ctrl = {control[CTRL_RSV_HIGH:CTRL_RSV_LOW],
                      pin_sync[0] ? factory_base : AS_FACTORY_ADDR[BOOT_ADDR_W-1:2],
                      control[CTRL_WD_MSB:CTRL_WD_LSB]};
  assign ctrl_write = init_pending | (state == RCF_CAPTURE) | fallback_ev;
  // An application image never loads the update copy; an error there returns to the factory address.
  assign next_control = init_pending ? init_ctrl :
                        ((state == RCF_CAPTURE) && FACTORY_IMAGE) ? update_copy :
                        factory_ctrl;
  assign next_status = {1'b0, src_onehot, mstate, BOOT_ADDRESS};

  always_comb
  begin
    next_state = state;
    case (state)
      RCF_IDLE:
        if (|src_pend)
          next_state = RCF_CAPTURE;
      RCF_CAPTURE:
        next_state = RCF_ISSUE;
      RCF_ISSUE:
        next_state = RCF_IDLE;
      default:
        next_state = RCF_IDLE;
    endcase
  end

  // REF_CLK stands for whichever slow clock the device picks for this side.
  always_ff @(posedge REF_CLK)
  begin
    if (!RESETN)
    begin
      state <= RCF_IDLE;
      control <= CTRL_RESET;
      status <= STATUS_RESET;
      factory_base <= AP_FACTORY_ADDR[BOOT_ADDR_W-1:2];
      src_pend <= '0;
      cfg_n_d <= 1'b1;
      ext_n_d <= 1'b1;
      req_n_d <= 1'b1;
      init_pending <= 1'b1;
      fallback_ev <= 1'b0;
      start_q <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cfg_n_d <= pin_sync[4];
      ext_n_d <= pin_sync[3];
      req_n_d <= pin_sync[2];
      init_pending <= 1'b0;
      // A source that fires while the pending set is taken is kept.
      src_pend <= ((state == RCF_CAPTURE) ? '0 : src_pend) | src_event;
      fallback_ev <= premature_done | image_bad;
      start_q <= (state == RCF_CAPTURE);
      if (SET_FACTORY_ADDR)
        factory_base <= SET_FACTORY_ADDR_VALUE[BOOT_ADDR_W-1:2];
      if (ctrl_write)
        control <= next_control;
      if (state == RCF_CAPTURE)
        status <= next_status;
    end
  end

  assign RECONFIG_START = start_q;
  assign FACTORY_FALLBACK = fallback_ev;
  assign BOOT_ADDRESS = {control[CTRL_ADDR_MSB:CTRL_ADDR_LSB], BOOT_ADDR_PAD};
  assign WATCHDOG_COUNT = {control[CTRL_WD_MSB:CTRL_WD_LSB], WD_LOW_BITS};
  assign WATCHDOG_ENABLE = control[CTRL_WATCHDOG_ENABLE];
  assign STARTUP_OSC_SELECT = control[CTRL_OSC_INT];
  assign EARLY_DONE_CHECK = control[CTRL_EARLY_DONE];

  // User clock domain: shift and update registers. The clock may stop at any time.
  logic [1:0] user_sync;
  logic user_rst_n;
  logic factory_user;
  logic [CTRL_W-1:0] shift_reg;
  logic [CTRL_W-1:0] update_reg;
  logic [CTRL_W-1:0] control_user;
  logic [STATUS_W-1:0] status_user;
  logic [CTRL_W-1:0] capture_src;
  logic capture_op;
  logic update_op;
  logic update_op_d;
  logic update_accept;

  rup_sync #(.WIDTH(2)) user_pins (
    .clk(UPG_USER_CLOCK),
    .d({RESETN, FACTORY_IMAGE}),
    .q(user_sync)
  );
  assign user_rst_n = user_sync[1];
  assign factory_user = user_sync[0];

  assign capture_op = ~UPG_SHIFT_NOT_LOAD & UPG_CAPTURE_NOT_UPDATE;
  assign update_op = ~UPG_SHIFT_NOT_LOAD & ~UPG_CAPTURE_NOT_UPDATE;
  assign update_accept = update_op & ~update_op_d & factory_user;
  assign capture_src = UPG_READ_STATUS ? {{(CTRL_W-STATUS_W){1'b0}}, status_user} :
                       factory_user ? update_reg : control_user;

  always_ff @(posedge UPG_USER_CLOCK)
  begin
    if (!user_rst_n)
    begin
      shift_reg <= '0;
      update_reg <= CTRL_RESET;
      update_op_d <= 1'b0;
    end
    else
    begin
      update_op_d <= update_op;
      if (UPG_SHIFT_NOT_LOAD)
        shift_reg <= {UPG_SERIAL_IN, shift_reg[CTRL_W-1:1]};
      else if (capture_op)
        shift_reg <= capture_src;
      if (update_accept)
        update_reg <= shift_reg;
    end
  end

  assign UPG_SERIAL_OUT = shift_reg[0];

  rup_word_xfer #(.WIDTH(CTRL_W)) update_to_ref (
    .src_clk(UPG_USER_CLOCK),
    .src_rst_n(user_rst_n),
    .src_load(update_accept),
    .src_data(shift_reg),
    .dst_clk(REF_CLK),
    .dst_rst_n(RESETN),
    .dst_data(update_copy)
  );

  rup_word_xfer #(.WIDTH(CTRL_W)) control_to_user (
    .src_clk(REF_CLK),
    .src_rst_n(RESETN),
    .src_load(ctrl_write),
    .src_data(next_control),
    .dst_clk(UPG_USER_CLOCK),
    .dst_rst_n(user_rst_n),
    .dst_data(control_user)
  );

  rup_word_xfer #(.WIDTH(STATUS_W)) status_to_user (
    .src_clk(REF_CLK),
    .src_rst_n(RESETN),
    .src_load(state == RCF_CAPTURE),
    .src_data(next_status),
    .dst_clk(UPG_USER_CLOCK),
    .dst_rst_n(user_rst_n),
    .dst_data(status_user)
  );

  sequence s_early_done;
    EARLY_DONE_CHECK && CONFIG_LOADING && pin_sync[1];
  endsequence

  sequence s_fallback_seen;
    FACTORY_FALLBACK ##1 (BOOT_ADDRESS[BOOT_ADDR_W-1:2] == factory_base);
  endsequence

  a_cause_priority: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (state == RCF_CAPTURE && src_pend[SRC_CFG_PIN]) |=> status[ST_SRC_MSB:ST_SRC_LSB] == 5'h10)
    else $error("Highest cause did not win.");
  a_cause_onehot: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    state == RCF_CAPTURE |=> $onehot(status[ST_SRC_MSB:ST_SRC_LSB]) ##0 RECONFIG_START ##1 !RECONFIG_START)
    else $error("Status cause or start pulse wrong.");
  a_ctrl_copy: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (state == RCF_CAPTURE && FACTORY_IMAGE) |=> control == $past(update_copy))
    else $error("Control did not take the update copy.");
  a_ctrl_hold: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (!init_pending && state != RCF_CAPTURE && !fallback_ev) |=> $stable(control))
    else $error("Control changed outside a reconfiguration.");
  a_serial_boot: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (init_pending && !pin_sync[0]) |=> BOOT_ADDRESS == 24'h000000)
    else $error("Serial scheme boot address not zero.");
  a_parallel_boot: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (init_pending && pin_sync[0] && factory_base == 22'h004000) |=> BOOT_ADDRESS == 24'h010000)
    else $error("Parallel scheme boot address wrong.");
  a_wd_count: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    ctrl_write |=> WATCHDOG_COUNT == {$past(next_control[11:0]), 17'h00008})
    else $error("Watchdog count does not follow the timeout field.");
  a_early_fall: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    s_early_done |=> s_fallback_seen)
    else $error("Early done did not fall back to factory.");
  a_update_refuse: assert property (@(posedge UPG_USER_CLOCK) disable iff (!user_rst_n)
    (update_op && !update_op_d && !factory_user) |=> $stable(update_reg))
    else $error("Update written under an application image.");
  a_shift_move: assert property (@(posedge UPG_USER_CLOCK) disable iff (!user_rst_n)
    UPG_SHIFT_NOT_LOAD |=> shift_reg == {$past(UPG_SERIAL_IN), $past(shift_reg[38:1])})
    else $error("Shift register did not move one bit.");
  a_read_ctrl: assert property (@(posedge UPG_USER_CLOCK) disable iff (!user_rst_n)
    (capture_op && !UPG_READ_STATUS && !factory_user) |=> shift_reg == $past(control_user))
    else $error("Application read did not load control.");
  a_read_update: assert property (@(posedge UPG_USER_CLOCK) disable iff (!user_rst_n)
    (capture_op && !UPG_READ_STATUS && factory_user) |=> shift_reg == $past(update_reg))
    else $error("Factory read did not load update.");
  a_read_status: assert property (@(posedge UPG_USER_CLOCK) disable iff (!user_rst_n)
    (capture_op && UPG_READ_STATUS) |=> shift_reg == {7'h00, $past(status_user)})
    else $error("Status capture did not load status.");
endmodule : rup_remote_upgrade_regs

// ### verification/rup_fabric_model.sv
`timescale 1ns/100ps
module rup_fabric_model (
  input wire logic clk,
  input wire logic serial_out,
  output logic serial_in,
  output logic shift_not_load,
  output logic capture_not_update
);
  // Idle is capture: an idle update would overwrite the update register.
  initial
  begin
    serial_in = 1'b0;
    shift_not_load = 1'b0;
    capture_not_update = 1'b1;
  end

  task automatic read_word(output logic [38:0] d);
    @(posedge clk);
    shift_not_load <= 1'b0;
    capture_not_update <= 1'b1;
    @(posedge clk);
    shift_not_load <= 1'b1;
    for (int i = 0; i < 39; i++)
    begin
      @(posedge clk);
      d[i] = serial_out;
    end
    shift_not_load <= 1'b0;
  endtask : read_word

  task automatic write_word(input logic [38:0] d);
    for (int i = 0; i < 39; i++)
    begin
      @(posedge clk);
      shift_not_load <= 1'b1;
      serial_in <= d[i];
    end
    @(posedge clk);
    shift_not_load <= 1'b0;
    capture_not_update <= 1'b0;
    serial_in <= ~d[38];
    @(posedge clk);
    capture_not_update <= 1'b1;
  endtask : write_word
endmodule : rup_fabric_model

// ### verification/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import rup_pkg::*;
  logic ref_clk, uclk, rst_n, rsel, img, aps, set_fa, chk_fail, loading, done_pin;
  logic [23:0] fa_val, v;
  logic [4:0] ev;
  logic [38:0] w, got;
  logic sin, snl, cnu, sout, start, fb, wden, oscs, edc;
  logic [23:0] boot;
  logic [28:0] wdc;
  logic [23:0] boot_q[$];
  int fail_count = 0;
  int cmp_count = 0;

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial
  begin
    uclk = 1'b0;
    #3;
    forever #16 uclk = ~uclk;
  end

  rup_fabric_model fab (.clk(uclk), .serial_out(sout), .serial_in(sin), .shift_not_load(snl),
    .capture_not_update(cnu));

  rup_remote_upgrade_regs DUT (.REF_CLK(ref_clk), .RESETN(rst_n), .UPG_USER_CLOCK(uclk), .UPG_SERIAL_IN(sin),
    .UPG_SHIFT_NOT_LOAD(snl), .UPG_CAPTURE_NOT_UPDATE(cnu), .UPG_READ_STATUS(rsel), .UPG_SERIAL_OUT(sout),
    .UPG_RECONFIG_REQUEST_N(~ev[0]), .FACTORY_IMAGE(img), .ACTIVE_PARALLEL_SCHEME(aps),
    .SET_FACTORY_ADDR(set_fa), .SET_FACTORY_ADDR_VALUE(fa_val), .CONFIG_RESET_N(~ev[4]),
    .EXT_STATUS_N(~ev[2]), .CRC_ERROR(ev[3]), .WATCHDOG_TIMEOUT(ev[1]), .CONFIG_DONE(done_pin),
    .CONFIG_LOADING(loading), .IMAGE_CHECK_FAIL(chk_fail), .RECONFIG_START(start), .FACTORY_FALLBACK(fb),
    .BOOT_ADDRESS(boot), .WATCHDOG_COUNT(wdc), .WATCHDOG_ENABLE(wden), .STARTUP_OSC_SELECT(oscs),
    .EARLY_DONE_CHECK(edc));

  task automatic cmp(input string nm, input logic [38:0] e, input logic [38:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  // Each reconfiguration start takes the oldest expected boot address.
  always @(posedge ref_clk)
    if (start === 1'b1 && boot_q.size() != 0)
      cmp("boot address at start", {15'h0, boot_q.pop_front()}, {15'h0, boot});

  task automatic do_reset(input logic ap);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    aps <= ap;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge uclk);
  endtask : do_reset

  task automatic rd_chk(input string nm, input logic sel, input logic [38:0] e, input logic [38:0] m);
    repeat (6) @(posedge uclk);
    rsel <= sel;
    fab.read_word(got);
    cmp(nm, e & m, got & m);
    rsel <= 1'b0;
  endtask : rd_chk

  // Pins are held low for several cycles so the synchroniser sees them; pulses last one cycle.
  task automatic fire(input logic [4:0] m, input logic [23:0] eb);
    boot_q.push_back(eb);
    @(posedge ref_clk);
    ev <= m;
    @(posedge ref_clk);
    ev <= m & 5'h15;
    repeat (4) @(posedge ref_clk);
    ev <= 5'h00;
    for (int i = 0; i < 40 && boot_q.size() != 0; i++)
      @(posedge ref_clk);
    if (boot_q.size() != 0)
      cmp("reconfiguration start", 39'h1, 39'h0);
  endtask : fire

  initial
  begin
    rst_n = 1'b0;
    rsel = 1'b0;
    img = 1'b1;
    aps = 1'b0;
    set_fa = 1'b0;
    chk_fail = 1'b0;
    loading = 1'b0;
    done_pin = 1'b0;
    fa_val = 24'h000000;
    ev = 5'h00;
    void'($urandom(98));
    do_reset(1'b0);
    cmp("serial scheme boot", 39'h0, {15'h0, boot});
    $display("test power up done");
    w = 39'({$urandom, $urandom});
    w[37:36] = 2'h3;
    fab.write_word(w);
    rd_chk("update readback", 1'b0, w, {39{1'b1}});
    for (int s = 0; s < 5; s++)
    begin
      fire(5'(1 << s), {w[33:12], 2'h0});
      rd_chk("status cause", 1'b1, {8'h0, 5'(1 << s), 2'h0, 24'h0}, 39'h7FFF000000);
    end
    cmp("watchdog count", {10'h0, w[11:0], 17'h00008}, {10'h0, wdc});
    cmp("option bits", {36'h0, w[37:35]}, {36'h0, edc, oscs, wden});
    fire(5'h0A, {w[33:12], 2'h0});
    rd_chk("tie cause", 1'b1, {8'h0, 5'h08, 2'h0, 24'h0}, 39'h7FFF000000);
    $display("test reconfiguration done");
    img <= 1'b0;
    rd_chk("application read", 1'b0, w, {39{1'b1}});
    fab.write_word(~w);
    img <= 1'b1;
    rd_chk("refused write", 1'b0, w, {39{1'b1}});
    $display("test image access done");
    // The early done check bit is still set from the last copy, so fallback is armed here.
    v = 24'($urandom);
    @(posedge ref_clk);
    set_fa <= 1'b1;
    fa_val <= v;
    @(posedge ref_clk);
    set_fa <= 1'b0;
    chk_fail <= 1'b1;
    @(posedge ref_clk);
    chk_fail <= 1'b0;
    #1;
    cmp("factory fallback", 39'h1, {38'h0, fb});
    @(posedge ref_clk);
    #1;
    cmp("replaced factory address", {15'h0, v[23:2], 2'h0}, {15'h0, boot});
    @(posedge ref_clk);
    loading <= 1'b1;
    done_pin <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    cmp("early done fallback", 39'h1, {38'h0, fb});
    @(posedge ref_clk);
    loading <= 1'b0;
    done_pin <= 1'b0;
    $display("test fallback done");
    do_reset(1'b1);
    cmp("parallel scheme boot", {15'h0, AP_FACTORY_ADDR}, {15'h0, boot});
    $display("test parallel scheme done");
    report_and_stop();
  end

  initial
  begin
    #500us;
    fail_count++;
    report_and_stop();
  end
endmodule : tb_top
